/* design/pcg_regs.vh */
// Register offsets, field positions and timing constants for the PCIe core clock gating block.
`ifndef PCG_REGS_VH
`define PCG_REGS_VH
`define PCG_IDX_PDNB 8'h07
`define PCG_IDX_CFG 8'h11
`define PCG_IDX_PWR 8'h40
`define PCG_IDX_CGDIS 8'h94
`define PCG_IDX_SPARE 8'he8
`define PCG_IDX_STAT 8'hf0
`define PCG_IDX_W 8
`define PCG_ADDR_W 10
`define PCG_BIT_TX_G1 4
`define PCG_BIT_TX_G2 5
`define PCG_BIT_TX_G3A 6
`define PCG_BIT_TX_SB 7
`define PCG_BIT_TX_G3B 24
`define PCG_BIT_PAD_PD 6
`define PCG_LAT_HI 3
`define PCG_LAT_LO 0
`define PCG_BIT_LC_DIS_G1 22
`define PCG_BIT_LC_DIS_SB 24
`define PCG_BIT_LC_EN_G2 28
`define PCG_BIT_LC_EN_G3A 31
`define PCG_BIT_LC_EN_G3B 25
`define PCG_RST_PDNB 32'h0000_0000
`define PCG_RST_CFG 32'h0000_000c
`define PCG_RST_PWR 32'h0000_0000
`define PCG_RST_CGDIS 32'h0140_0000
`define PCG_RST_SPARE 32'h0000_0000
`define PCG_NCORE 5
`define PCG_LINKS 4
`define PCG_LANES_PER_PAD 4
`define PCG_PADS 4
`define PCG_LAT_W 4
`define PCG_PRESCALE 8'h0f
`endif

/* design/pcg_sync.v */
// Two-flop synchroniser for a bus of level signals from outside the clock domain.
`timescale 1ns/1ps
module pcg_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // pcg_sync

/* design/pcg_core_gate.v */
// Per-core gate controller: qualifies L1 entry with a latency, releases gates at once on L1 exit.
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_core_gate (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  input wire tick,
  // Controls
  input wire tx_en,
  input wire lc_en,
  input wire pad_en,
  input wire [`PCG_LAT_W-1:0] gating_latency,
  // Link state, synchronised
  input wire [`PCG_LINKS-1:0] link_used,
  input wire [`PCG_LINKS-1:0] link_in_l1,
  // Gate outputs
  output reg tx_gate,
  output reg lc_gate,
  output reg [`PCG_PADS-1:0] pad_pd
);
  localparam [`PCG_LAT_W-1:0] LAT_ZERO = 4'h0;
  reg [`PCG_LAT_W-1:0] any_cnt_r;
  reg [`PCG_LAT_W-1:0] all_cnt_r;
  wire [`PCG_LINKS-1:0] l1_used = link_in_l1 & link_used;
  wire any_l1 = |l1_used;
  wire all_l1 = (link_used != {`PCG_LINKS{1'b0}}) && ((link_in_l1 | ~link_used) == {`PCG_LINKS{1'b1}});
  // Gating only after the link has sat in L1 for the latency, so a short dip causes no clock glitch.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      any_cnt_r <= LAT_ZERO;
      all_cnt_r <= LAT_ZERO;
      tx_gate <= 1'b0;
      lc_gate <= 1'b0;
      pad_pd <= {`PCG_PADS{1'b0}};
    end else begin
      if (!any_l1) begin
        any_cnt_r <= LAT_ZERO;
      end else if (tick && any_cnt_r != gating_latency) begin
        any_cnt_r <= any_cnt_r + 4'h1;
      end
      if (!all_l1) begin
        all_cnt_r <= LAT_ZERO;
      end else if (tick && all_cnt_r != gating_latency) begin
        all_cnt_r <= all_cnt_r + 4'h1;
      end
      tx_gate <= tx_en && any_l1 && (any_cnt_r == gating_latency);
      lc_gate <= lc_en && all_l1 && (all_cnt_r == gating_latency);
      // Each pad feeds one four-lane group, tracked by one link-state bit.
      pad_pd <= (tx_en && pad_en && any_cnt_r == gating_latency) ? l1_used : {`PCG_PADS{1'b0}};
    end
  end
endmodule // pcg_core_gate

/* design/pcg_top.v */
// Top of the PCIe core L1 clock gating block with its Avalon-MM register slave.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pcg_regs.vh"
module pcg_top (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Avalon-MM slave, word address
  input wire [`PCG_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  // Link state per core: core order is group one, two, southbridge, three-a, three-b
  input wire [19:0] link_in_l1,
  input wire [19:0] link_used,
  // Clock gate controls, one bit per core; pad powerdown one bit per link
  output reg [`PCG_NCORE-1:0] transmit_clock_gate,
  output reg [`PCG_NCORE-1:0] link_core_clock_gate,
  output reg [19:0] rx_side_clock_pad_powerdown
);
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_DECERR = 2'h3;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACK = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  localparam NC = `PCG_NCORE;
  localparam NL = `PCG_LINKS;

  reg [31:0] core_powerdown_control_r;
  reg [31:0] core_config_control_r;
  reg [31:0] core_power_control_r;
  reg [31:0] clock_gate_disable_bits_r;
  reg [31:0] top_clock_spare_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] pre_r;
  reg tick_r;
  wire [19:0] l1_s;
  wire [19:0] used_s;
  wire [NC-1:0] tx_en;
  wire [NC-1:0] lc_en;
  wire [NC-1:0] tx_g;
  wire [NC-1:0] lc_g;
  wire [19:0] pad_g;
  wire [`PCG_IDX_W-1:0] idx = avs_address[`PCG_IDX_W-1:0];
  wire addr_hi_ok = (avs_address[`PCG_ADDR_W-1:`PCG_IDX_W] == 2'h0);

  // Decoded once for the response to both reads and writes; the read and write data paths decode idx in their own case.
  function hit;
    input [`PCG_IDX_W-1:0] a;
    begin
      hit = (a == `PCG_IDX_PDNB) || (a == `PCG_IDX_CFG) || (a == `PCG_IDX_PWR) ||
            (a == `PCG_IDX_CGDIS) || (a == `PCG_IDX_SPARE) || (a == `PCG_IDX_STAT);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  pcg_sync #(.W(20)) u_sync_l1 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d(link_in_l1),
    .q(l1_s)
  );

  pcg_sync #(.W(20)) u_sync_used (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d(link_used),
    .q(used_s)
  );

  // Per-core enables from the register fields.
  assign tx_en[0] = core_powerdown_control_r[`PCG_BIT_TX_G1];
  assign tx_en[1] = core_powerdown_control_r[`PCG_BIT_TX_G2];
  assign tx_en[2] = core_powerdown_control_r[`PCG_BIT_TX_SB];
  assign tx_en[3] = core_powerdown_control_r[`PCG_BIT_TX_G3A];
  assign tx_en[4] = core_powerdown_control_r[`PCG_BIT_TX_G3B];
  assign lc_en[0] = ~clock_gate_disable_bits_r[`PCG_BIT_LC_DIS_G1];
  assign lc_en[1] = top_clock_spare_r[`PCG_BIT_LC_EN_G2];
  assign lc_en[2] = ~clock_gate_disable_bits_r[`PCG_BIT_LC_DIS_SB];
  assign lc_en[3] = top_clock_spare_r[`PCG_BIT_LC_EN_G3A];
  assign lc_en[4] = top_clock_spare_r[`PCG_BIT_LC_EN_G3B];

  // The latency counts prescaled ticks; the value is shared by all cores.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (pre_r == `PCG_PRESCALE);
      pre_r <= (pre_r == `PCG_PRESCALE) ? 8'h00 : pre_r + 8'h01;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1) begin : g_core
      pcg_core_gate u_gate (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(tick_r),
        .tx_en(tx_en[g]),
        .lc_en(lc_en[g]),
        .pad_en(core_power_control_r[`PCG_BIT_PAD_PD]),
        .gating_latency(core_config_control_r[`PCG_LAT_HI:`PCG_LAT_LO]),
        .link_used(used_s[g*NL +: NL]),
        .link_in_l1(l1_s[g*NL +: NL]),
        .tx_gate(tx_g[g]),
        .lc_gate(lc_g[g]),
        .pad_pd(pad_g[g*NL +: NL])
      );
    end
  endgenerate

  // Exit from L1 clears the transmit and pad gates on the edge after the synchronised link state shows it; the link-core gate clears one cycle later via lc_g.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      transmit_clock_gate <= {NC{1'b0}};
      link_core_clock_gate <= {NC{1'b0}};
      rx_side_clock_pad_powerdown <= 20'h00000;
    end else begin
      transmit_clock_gate <= tx_g & l1_s_any(l1_s & used_s);
      link_core_clock_gate <= lc_g;
      rx_side_clock_pad_powerdown <= pad_g & l1_s & used_s;
    end
  end

  function [NC-1:0] l1_s_any;
    input [19:0] v;
    integer k;
    begin
      l1_s_any = {NC{1'b0}};
      for (k = 0; k < NC; k = k + 1) begin
        l1_s_any[k] = |v[k*NL +: NL];
      end
    end
  endfunction

  // Bus handshake: request taken in idle, one answer cycle, then one hold cycle back to idle.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (avs_read || avs_write) begin
          state_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= RESP_OK;
      core_powerdown_control_r <= `PCG_RST_PDNB;
      core_config_control_r <= `PCG_RST_CFG;
      core_power_control_r <= `PCG_RST_PWR;
      clock_gate_disable_bits_r <= `PCG_RST_CGDIS;
      top_clock_spare_r <= `PCG_RST_SPARE;
    end else begin
      state_r <= state_nxt;
      avs_waitrequest <= ~(state_r == ST_IDLE && (avs_read || avs_write));
      if (state_r == ST_IDLE && (avs_read || avs_write)) begin
        avs_response <= (hit(idx) && addr_hi_ok) ? RESP_OK : RESP_DECERR;
        avs_readdata <= 32'h0000_0000;
        if (avs_read && addr_hi_ok) begin
          case (idx)
            `PCG_IDX_PDNB: avs_readdata <= core_powerdown_control_r;
            `PCG_IDX_CFG: avs_readdata <= core_config_control_r;
            `PCG_IDX_PWR: avs_readdata <= core_power_control_r;
            `PCG_IDX_CGDIS: avs_readdata <= clock_gate_disable_bits_r;
            `PCG_IDX_SPARE: avs_readdata <= top_clock_spare_r;
            `PCG_IDX_STAT: avs_readdata <= {17'h00000, link_core_clock_gate, 5'h00, transmit_clock_gate};
            default: avs_readdata <= 32'h0000_0000;
          endcase
        end
        if (avs_write && addr_hi_ok) begin
          case (idx)
            `PCG_IDX_PDNB: core_powerdown_control_r <= merge(core_powerdown_control_r, avs_writedata, avs_byteenable);
            `PCG_IDX_CFG: core_config_control_r <= merge(core_config_control_r, avs_writedata, avs_byteenable);
            `PCG_IDX_PWR: core_power_control_r <= merge(core_power_control_r, avs_writedata, avs_byteenable);
            `PCG_IDX_CGDIS: clock_gate_disable_bits_r <= merge(clock_gate_disable_bits_r, avs_writedata, avs_byteenable);
            `PCG_IDX_SPARE: top_clock_spare_r <= merge(top_clock_spare_r, avs_writedata, avs_byteenable);
            default: core_config_control_r <= core_config_control_r;
          endcase
        end
      end
    end
  end
endmodule // pcg_top

/* tb/pcg_top_properties.sv */
// Concurrent checks on the ports of the PCIe core L1 clock gating block.
`timescale 1ns/1ps
module pcg_top_properties (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Register bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  // Link state and gates
  input wire [19:0] link_in_l1,
  input wire [19:0] link_used,
  input wire [4:0] transmit_clock_gate,
  input wire [4:0] link_core_clock_gate,
  input wire [19:0] rx_side_clock_pad_powerdown
);
  logic [4:0] all_l1;
  logic [4:0] none_l1;
  wire mapped = avs_address[9:8] == 2'h0 && (avs_address[7:0] inside {8'h07, 8'h11, 8'h40, 8'h94, 8'he8, 8'hf0});
  // A core with no used link counts as neither fully in L1 nor fully out of it.
  always_comb begin
    for (int c = 0; c < 5; c++) begin
      all_l1[c] = |link_used[4*c+:4] && ((link_used[4*c+:4] & ~link_in_l1[4*c+:4]) == 4'h0);
      none_l1[c] = |link_used[4*c+:4] && ((link_used[4*c+:4] & link_in_l1[4*c+:4]) == 4'h0);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Link pins must stay put long enough to pass the synchroniser and the gate flops.
  sequence s_quiet; ($stable(link_in_l1) && $stable(link_used)) [*7]; endsequence
  property p_wait_pulse; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  property p_wait_cause; !avs_waitrequest |-> $past(avs_read) || $past(avs_write); endproperty
  property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  property p_decerr; !avs_waitrequest && avs_read && !mapped |-> avs_response == 2'h3 && avs_readdata == 32'h0;
  endproperty
  property p_okresp; !avs_waitrequest && mapped |-> avs_response == 2'h0; endproperty
  property p_tx_out; s_quiet |-> (transmit_clock_gate & none_l1) == 5'h0; endproperty
  property p_lc_all; s_quiet |-> (link_core_clock_gate & ~all_l1) == 5'h0; endproperty
  property p_pad_own; s_quiet |-> (rx_side_clock_pad_powerdown & ~link_in_l1) == 20'h0; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (p_wait_cause) else $error("waitrequest low without a request");
  a_answer: assert property (p_answer) else $error("request not answered in the next cycle");
  a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
  a_okresp: assert property (p_okresp) else $error("mapped access not answered okay");
  a_tx_out: assert property (p_tx_out) else $error("transmit clock gated outside L1");
  a_lc_all: assert property (p_lc_all) else $error("link-core clock gated with a link out of L1");
  a_pad_own: assert property (p_pad_own) else $error("pad powered down with its link out of L1");
  c_tx: cover property ($rose(|transmit_clock_gate));
  c_lc: cover property ($rose(|link_core_clock_gate));
  c_err: cover property (!avs_waitrequest && avs_response == 2'h3);
endmodule // pcg_top_properties

/* tb/pcg_top_tb.sv */
// Self-checking testbench for the PCIe core L1 clock gating block.
`timescale 1ns/1ps
module pcg_top_tb;
  logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [9:0] avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] avs_response, r;
  logic [19:0] link_in_l1 = 20'h0, link_used = 20'hfffff, rx_side_clock_pad_powerdown;
  logic [4:0] transmit_clock_gate, link_core_clock_gate;
  int error_cnt = 0, n_tests = 0;
  pcg_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .link_in_l1(link_in_l1), .link_used(link_used), .transmit_clock_gate(transmit_clock_gate),
    .link_core_clock_gate(link_core_clock_gate), .rx_side_clock_pad_powerdown(rx_side_clock_pad_powerdown));
  initial forever #10 clk_sys = ~clk_sys;
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The slave needs one idle cycle after each answer, so the task lets two edges pass.
  task automatic bus(input bit wr, input [9:0] a, input [31:0] d, input [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 32'h1, {31'h0, n < 50});
    repeat (2) @(posedge clk_sys);
  endtask
  function automatic [19:0] pick(input int s);
    case (s)
      0: pick = {15'h0, transmit_clock_gate};
      1: pick = {15'h0, link_core_clock_gate};
      default: pick = rx_side_clock_pad_powerdown;
    endcase
  endfunction
  task automatic wsig(input int s, input [19:0] e);
    int n;
    n = 0;
    while (pick(s) !== e && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [9:0] a [6] = '{10'h007, 10'h011, 10'h040, 10'h094, 10'h0e8, 10'h0f0};
    logic [31:0] v [6] = '{32'h0, 32'hc, 32'h0, 32'h01400000, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      bus(0, a[i], 32'h0, 4'hf);
      chk("reset value", v[i], q);
    end
    bus(0, 10'h003, 32'h0, 4'hf);
    chk("unmapped data", 32'h0, q);
    chk("unmapped resp", 32'h3, {30'h0, r});
    bus(0, 10'h107, 32'h0, 4'hf);
    chk("high index resp", 32'h3, {30'h0, r});
    bus(1, 10'h107, 32'hffffffff, 4'hf);
    chk("high index write resp", 32'h3, {30'h0, r});
    bus(0, 10'h007, 32'h0, 4'hf);
    chk("high index write ignored", 32'h0, q);
    bus(1, 10'h0f0, 32'hffffffff, 4'hf);
    bus(0, 10'h0f0, 32'h0, 4'hf);
    chk("status read only", 32'h0, q);
    bus(1, 10'h011, 32'hffffff05, 4'h1);
    chk("write resp", 32'h0, {30'h0, r});
    bus(0, 10'h011, 32'h0, 4'hf);
    chk("byte lane merge", 32'h5, q);
    bus(1, 10'h011, 32'hc, 4'hf);
  endtask
  task automatic t_tx;
    int bp [5] = '{4, 5, 7, 6, 24};
    for (int c = 0; c < 5; c++) begin
      link_in_l1 <= 20'hf << (4 * c);
      repeat (260) @(posedge clk_sys);
      chk("tx gate off", 32'h0, {27'h0, transmit_clock_gate});
      bus(1, 10'h007, 32'h1 << bp[c], 4'hf);
      wsig(0, 20'h1 << c);
      chk("tx gate", 32'h1 << c, {27'h0, transmit_clock_gate});
      bus(0, 10'h0f0, 32'h0, 4'hf);
      chk("status tx", 32'h1 << c, q & 32'h1f);
      link_in_l1 <= 20'h0;
      repeat (6) @(posedge clk_sys);
      chk("tx ungate", 32'h0, {27'h0, transmit_clock_gate});
      bus(1, 10'h007, 32'h0, 4'hf);
    end
  endtask
  task automatic t_pad;
    link_in_l1 <= 20'h500;
    bus(1, 10'h007, 32'h80, 4'hf);
    // Twelve ticks of sixteen cycles cannot have passed yet, so the gate must still be open.
    repeat (150) @(posedge clk_sys);
    chk("tx before latency", 32'h0, {27'h0, transmit_clock_gate});
    repeat (110) @(posedge clk_sys);
    chk("tx after latency", 32'h4, {27'h0, transmit_clock_gate});
    chk("pad off", 32'h0, {12'h0, rx_side_clock_pad_powerdown});
    bus(1, 10'h040, 32'h40, 4'hf);
    wsig(2, 20'h500);
    chk("pad per group", 32'h500, {12'h0, rx_side_clock_pad_powerdown});
    link_in_l1 <= 20'h0;
    repeat (6) @(posedge clk_sys);
    chk("pad on", 32'h0, {12'h0, rx_side_clock_pad_powerdown});
    bus(1, 10'h007, 32'h0, 4'hf);
    bus(1, 10'h040, 32'h0, 4'hf);
  endtask
  task automatic t_lc;
    logic [9:0] a [5] = '{10'h094, 10'h0e8, 10'h094, 10'h0e8, 10'h0e8};
    logic [31:0] d [5] = '{32'h01000000, 32'h10000000, 32'h00400000, 32'h80000000, 32'h02000000};
    for (int c = 0; c < 5; c++) begin
      bus(1, 10'h094, 32'h01400000, 4'hf);
      bus(1, 10'h0e8, 32'h0, 4'hf);
      link_in_l1 <= 20'h7 << (4 * c);
      link_used <= ~(20'h8 << (4 * c));
      repeat (260) @(posedge clk_sys);
      chk("lc disabled", 32'h0, {27'h0, link_core_clock_gate});
      link_used <= 20'hfffff;
      bus(1, a[c], d[c], 4'hf);
      repeat (260) @(posedge clk_sys);
      chk("lc partial L1", 32'h0, {27'h0, link_core_clock_gate});
      link_used <= ~(20'h8 << (4 * c));
      wsig(1, 20'h1 << c);
      chk("lc gate", 32'h1 << c, {27'h0, link_core_clock_gate});
      bus(0, 10'h0f0, 32'h0, 4'hf);
      chk("status lc", 32'h1 << c, (q >> 10) & 32'h1f);
      link_in_l1 <= 20'h0;
      repeat (6) @(posedge clk_sys);
      chk("lc ungate", 32'h0, {27'h0, link_core_clock_gate});
      link_used <= 20'hfffff;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_tx;
    t_pad;
    t_lc;
    tally_and_finish;
  end
  initial begin
    #400000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish;
  end
endmodule // pcg_top_tb
bind pcg_top pcg_top_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .link_in_l1(link_in_l1), .link_used(link_used), .transmit_clock_gate(transmit_clock_gate),
  .link_core_clock_gate(link_core_clock_gate), .rx_side_clock_pad_powerdown(rx_side_clock_pad_powerdown));
